// File: cjm_consts.svh
// Constants for the jump and move execution block
`ifndef CJM_CONSTS_SVH
`define CJM_CONSTS_SVH
`define CJM_OFF_W 10
`define CJM_COND_LSB 10
`define CJM_JUMP_TOP 3'h1
`define CJM_SR_C 0
`define CJM_SR_Z 1
`define CJM_SR_N 2
`define CJM_SR_GIE 3
`define CJM_SR_PROCESSOR_OFF_BIT 4
`define CJM_SR_OSCILLATOR_OFF_BIT 5
`define CJM_SR_V 8
`define CJM_PC_RST 16'h0000
`define CJM_PC_STEP 16'h0002
`endif

// File: cjm_pkg.sv
// Types for the jump and move execution block
package cjm_pkg;
  typedef enum logic [2:0] {
    jump_not_zero = 3'h0,
    jump_equal = 3'h1,
    jump_no_carry = 3'h2,
    jump_carry = 3'h3,
    jump_if_negative = 3'h4,
    jump_signed_ge = 3'h5,
    jump_signed_lt = 3'h6,
    jump_always = 3'h7
  } jump_cond_t;
  typedef enum logic [1:0] {
    op_none = 2'h0,
    op_jump = 2'h1,
    op_copy = 2'h2,
    op_nop = 2'h3
  } op_kind_t;
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_exec = 2'h1
  } exec_state_t;
  typedef struct packed {
    logic valid;
    logic [15:0] instr;
    op_kind_t kind;
    logic byte_mode;
    logic [15:0] src_val;
    logic [15:0] dst_old;
  } exec_req_t;
  typedef struct packed {
    logic wr_en;
    logic [15:0] wr_data;
  } dst_write_t;
endpackage : cjm_pkg

// File: cjm_copy_unit.sv
// Word and byte operand copy stage with registered result
`timescale 1ns/1ps
module cjm_copy_unit (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic byte_mode,
  input wire logic [15:0] src_val,
  input wire logic [15:0] dst_old,
  output cjm_pkg::dst_write_t wr
);
  cjm_pkg::dst_write_t wr_d;
  cjm_pkg::dst_write_t wr_q;

  // Byte form moves only the low 8 bits, high byte of result cleared
  always_comb begin
    wr_d.wr_en = start;
    wr_d.wr_data = wr_q.wr_data;
    if (start) begin
      if (byte_mode) begin
        wr_d.wr_data = {8'h00, src_val[7:0]};
      end else begin
        wr_d.wr_data = src_val;
      end
    end
  end

  // Old destination is discarded; source is only read, never written
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wr_q <= '0;
    end else begin
      wr_q <= wr_d;
    end
  end

  assign wr = wr_q;

  a_copy_byte: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    start && byte_mode |=> wr.wr_en && wr.wr_data[15:8] == 8'h00 &&
    wr.wr_data[7:0] == $past(src_val[7:0]))
    else $error("byte copy wrong");
  a_copy_word: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    start && !byte_mode |=> wr.wr_en && wr.wr_data == $past(src_val))
    else $error("word copy wrong");
  // dst_old is accepted for symmetry; the copy overwrites it entirely
  logic unused_old;
  assign unused_old = ^dst_old;
endmodule : cjm_copy_unit

// File: cond_jump_and_move_exec.sv
// Conditional jump, operand copy and no-operation execution
`timescale 1ns/1ps
`include "cjm_consts.svh"
// Operation
// - Taken jump adds doubled sign-extended offset
// - Signed ge jumps when N equals V
// - Signed lt jumps when N differs V
// - Unconditional jump always adds offset
// - Negative jump branches when N set
// - No-carry jump branches when C clear
// - Not-zero jump branches when Z clear
// - Copy writes source to destination
// - Byte copy moves only eight bits
// - Copy keeps mode bits of status
// - No-operation changes no state; here the PC still advances by 2
module cond_jump_and_move_exec (
  input wire logic ref_clk,
  input wire logic nrst,
  input cjm_pkg::exec_req_t req,
  input wire logic [15:0] sr_in,
  output logic req_ready,
  output logic [15:0] pc,
  output logic [15:0] sr_out,
  output logic sr_wr_en,
  output cjm_pkg::dst_write_t dst_wr,
  output logic done,
  output logic jump_taken
);
  cjm_pkg::exec_state_t state_q;
  cjm_pkg::exec_state_t state_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [15:0] sr_q;
  logic [15:0] sr_d;
  logic done_q;
  logic done_d;
  logic taken_q;
  logic taken_d;
  logic copy_start;
  logic take;
  cjm_pkg::jump_cond_t cond;

  // Condition code decode against the flag word
  function automatic logic cond_met(input cjm_pkg::jump_cond_t c,
                                    input logic [15:0] s);
    logic n;
    logic v;
    n = s[`CJM_SR_N];
    v = s[`CJM_SR_V];
    case (c)
      cjm_pkg::jump_not_zero: cond_met = !s[`CJM_SR_Z];
      cjm_pkg::jump_equal: cond_met = s[`CJM_SR_Z];
      cjm_pkg::jump_no_carry: cond_met = !s[`CJM_SR_C];
      cjm_pkg::jump_carry: cond_met = s[`CJM_SR_C];
      cjm_pkg::jump_if_negative: cond_met = n;
      cjm_pkg::jump_signed_ge: cond_met = (n == v);
      cjm_pkg::jump_signed_lt: cond_met = n ^ v;
      cjm_pkg::jump_always: cond_met = 1'b1;
      default: cond_met = 1'b0;
    endcase
  endfunction : cond_met

  // Offset counts from the next word: reach -512..+511 words; wraps in 16 bits
  function automatic logic [15:0] jump_target(input logic [15:0] p,
                                              input logic [15:0] ins);
    logic [15:0] ext;
    ext = {{(16 - `CJM_OFF_W){ins[`CJM_OFF_W-1]}}, ins[`CJM_OFF_W-1:0]};
    jump_target = p + `CJM_PC_STEP + {ext[14:0], 1'b0};
  endfunction : jump_target

  assign cond =
    cjm_pkg::jump_cond_t'(req.instr[`CJM_COND_LSB+2:`CJM_COND_LSB]);
  assign take = cond_met(cond, sr_in);
  assign req_ready = (state_q == cjm_pkg::st_idle);
  assign copy_start = req_ready && req.valid && req.kind == cjm_pkg::op_copy;

  // One request per two cycles: accept in idle, retire in exec
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    sr_d = sr_q;
    done_d = 1'b0;
    taken_d = taken_q;
    case (state_q)
      cjm_pkg::st_idle: begin
        if (req.valid && req.kind != cjm_pkg::op_none) begin
          state_d = cjm_pkg::st_exec;
          // Flags pass through untouched for every kind here
          sr_d = sr_in;
          taken_d = 1'b0;
          case (req.kind)
            cjm_pkg::op_jump: begin
              if (take) begin
                pc_d = jump_target(pc_q, req.instr);
                taken_d = 1'b1;
              end else begin
                pc_d = pc_q + `CJM_PC_STEP;
              end
            end
            // Copy and no-op only advance the PC
            cjm_pkg::op_copy: pc_d = pc_q + `CJM_PC_STEP;
            cjm_pkg::op_nop: pc_d = pc_q + `CJM_PC_STEP;
            default: pc_d = pc_q;
          endcase
        end
      end
      cjm_pkg::st_exec: begin
        state_d = cjm_pkg::st_idle;
        done_d = 1'b1;
      end
      default: state_d = cjm_pkg::st_idle;
    endcase
  end

  // Registers of the sequencer
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= cjm_pkg::st_idle;
      pc_q <= `CJM_PC_RST;
      sr_q <= 16'h0000;
      done_q <= 1'b0;
      taken_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      sr_q <= sr_d;
      done_q <= done_d;
      taken_q <= taken_d;
    end
  end

  cjm_copy_unit u_copy (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(copy_start),
    .byte_mode(req.byte_mode),
    .src_val(req.src_val),
    .dst_old(req.dst_old),
    .wr(dst_wr)
  );

  assign pc = pc_q;
  assign sr_out = sr_q;
  // Status is never written back; this block cannot change any flag
  assign sr_wr_en = 1'b0;
  assign done = done_q;
  assign jump_taken = taken_q;

  // Checks one cycle after the accepting edge, and on refused cycles
  a_jump_target: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_jump && take |=>
    pc == $past(pc) + `CJM_PC_STEP +
    {{5{$past(req.instr[9])}}, $past(req.instr[9:0]), 1'b0})
    else $error("jump target wrong");
  a_ge_taken: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_jump &&
    cond == cjm_pkg::jump_signed_ge |=>
    jump_taken == ($past(sr_in[`CJM_SR_N]) == $past(sr_in[`CJM_SR_V])))
    else $error("ge decision wrong");
  a_lt_taken: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_jump &&
    cond == cjm_pkg::jump_signed_lt |=>
    jump_taken == ($past(sr_in[`CJM_SR_N]) ^ $past(sr_in[`CJM_SR_V])))
    else $error("lt decision wrong");
  a_always_jump: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_jump &&
    cond == cjm_pkg::jump_always |=> jump_taken ##1 done)
    else $error("unconditional jump not taken");
  a_neg_jump: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_jump &&
    cond == cjm_pkg::jump_if_negative |=>
    jump_taken == $past(sr_in[`CJM_SR_N]))
    else $error("negative jump wrong");
  a_nc_jump: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_jump &&
    cond == cjm_pkg::jump_no_carry && sr_in[`CJM_SR_C] |=>
    pc == $past(pc) + `CJM_PC_STEP)
    else $error("no-carry fall through wrong");
  a_nz_jump: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_jump &&
    cond == cjm_pkg::jump_not_zero |=>
    jump_taken == !$past(sr_in[`CJM_SR_Z]))
    else $error("not-zero jump wrong");
  a_mode_kept: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_copy |=>
    sr_out[5:3] == $past(sr_in[5:3]) && !sr_wr_en)
    else $error("mode bits changed");
  a_nop_quiet: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_nop |=>
    !dst_wr.wr_en && !jump_taken && pc == $past(pc) + `CJM_PC_STEP)
    else $error("no-op changed state");
  a_flags_kept: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind != cjm_pkg::op_none |=>
    sr_out == $past(sr_in) && !sr_wr_en)
    else $error("flags modified");
  a_fall_through: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_jump && !take |=>
    pc == $past(pc) + `CJM_PC_STEP && !jump_taken)
    else $error("fall through wrong");
  a_busy_refused: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !req_ready |=> req_ready && done && pc == $past(pc) &&
    sr_out == $past(sr_out) && !dst_wr.wr_en)
    else $error("request taken while busy");
  a_idle_quiet: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && !(req.valid && req.kind != cjm_pkg::op_none) |=>
    req_ready && pc == $past(pc) && !dst_wr.wr_en && !done)
    else $error("idle request not ignored");
  a_nop_time: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    req_ready && req.valid && req.kind == cjm_pkg::op_nop |=>
    !req_ready ##1 done && req_ready)
    else $error("no-op timing wrong");
endmodule : cond_jump_and_move_exec

// File: cjm_far_side_model.sv
// Status register and destination register model beside the block
`timescale 1ns/1ps
module cjm_far_side_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [15:0] sr_set,
  input cjm_pkg::dst_write_t dst_wr,
  output logic [15:0] sr_in,
  output logic [15:0] dst_reg_q
);
  // Status word as the datapath holds it
  assign sr_in = sr_set;
  // Destination takes whatever the block writes
  always_ff @(posedge ref_clk) begin
    if (!nrst) dst_reg_q <= 16'hffff;
    else if (dst_wr.wr_en) dst_reg_q <= dst_wr.wr_data;
  end
endmodule : cjm_far_side_model

// File: cond_jump_and_move_exec_tb_top.sv
// Self-checking testbench for the jump and copy execution block
`timescale 1ns/1ps
`include "cjm_consts.svh"
module cond_jump_and_move_exec_tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  cjm_pkg::exec_req_t req = '0;
  logic [15:0] sr_set = 16'h0000;
  logic [15:0] sr_in, pc, sr_out, dst_q, exp_pc;
  logic req_ready, sr_wr_en, done, jump_taken;
  cjm_pkg::dst_write_t dst_wr;
  int miscompares = 0;
  int n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  cond_jump_and_move_exec dut (.ref_clk(ref_clk), .nrst(nrst), .req(req),
    .sr_in(sr_in), .req_ready(req_ready), .pc(pc), .sr_out(sr_out),
    .sr_wr_en(sr_wr_en), .dst_wr(dst_wr), .done(done),
    .jump_taken(jump_taken));
  cjm_far_side_model far (.ref_clk(ref_clk), .nrst(nrst), .sr_set(sr_set),
    .dst_wr(dst_wr), .sr_in(sr_in), .dst_reg_q(dst_q));
  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One request, held until the accepting edge; returns mid next cycle
  task automatic run(input cjm_pkg::op_kind_t k, input logic [15:0] ins,
                     input logic bm, input logic [15:0] src,
                     input logic [15:0] sr);
    int i;
    i = 0;
    while (req_ready !== 1'b1 && i < 10) begin
      @(negedge ref_clk);
      i++;
    end
    if (i == 10) begin
      miscompares++;
      finish_test();
    end
    req = '{1'b1, ins, k, bm, src, 16'h5a5a};
    sr_set = sr;
    @(negedge ref_clk);
    req.valid = 1'b0;
  endtask : run
  // Every condition against every flag mix, offsets at both reach limits
  task automatic jumps();
    logic [9:0] offs [4];
    logic [9:0] off;
    logic [15:0] sr;
    logic tk;
    offs = '{10'h1ff, 10'h200, 10'h001, 10'h3ff};
    for (int c = 0; c < 8; c++) begin
      for (int f = 0; f < 16; f++) begin
        sr = {8'h00, f[3:0], 4'h0} >> 4;
        sr[`CJM_SR_V] = f[3];
        sr[`CJM_SR_GIE] = f[0];
        off = offs[f[1:0]];
        case (c)
          0: tk = !sr[`CJM_SR_Z];
          2: tk = !sr[`CJM_SR_C];
          4: tk = sr[`CJM_SR_N];
          5: tk = sr[`CJM_SR_N] == sr[`CJM_SR_V];
          6: tk = sr[`CJM_SR_N] != sr[`CJM_SR_V];
          1: tk = sr[`CJM_SR_Z];
          3: tk = sr[`CJM_SR_C];
          default: tk = 1'b1;
        endcase
        // Offset counts from the word after the jump
        exp_pc = exp_pc + 16'h0002 + (tk ? {{5{off[9]}}, off, 1'b0} : 16'h0000);
        run(cjm_pkg::op_jump, {`CJM_JUMP_TOP, c[2:0], off}, 1'b0,
            16'h0000, sr);
        chk(pc, exp_pc);
        chk(jump_taken, tk);
        chk(sr_out, sr);
        chk(sr_wr_en, 1'b0);
        @(negedge ref_clk);
        chk(done, 1'b1);
      end
    end
  endtask : jumps
  // Word and byte copy with mode bits set, then a no-operation
  task automatic copies();
    logic [15:0] sr;
    sr = 16'h0138;
    for (int b = 0; b < 2; b++) begin
      exp_pc = exp_pc + 16'h0002;
      run(cjm_pkg::op_copy, 16'h4000, b[0], 16'ha5c3, sr);
      chk(dst_wr.wr_en, 1'b1);
      chk(dst_wr.wr_data, b ? 16'h00c3 : 16'ha5c3);
      chk(sr_out, sr);
      chk(pc, exp_pc);
      @(negedge ref_clk);
      chk(dst_wr.wr_en, 1'b0);
      chk(dst_q, b ? 16'h00c3 : 16'ha5c3);
    end
    exp_pc = exp_pc + 16'h0002;
    run(cjm_pkg::op_nop, 16'h4303, 1'b0, 16'h1234, 16'h0107);
    chk(dst_wr.wr_en, 1'b0);
    chk(pc, exp_pc);
    chk(sr_out, 16'h0107);
    @(negedge ref_clk);
    chk(dst_q, 16'h00c3);
  endtask : copies
  // Ignored idle request, then a jump held through its busy cycle
  task automatic refusals();
    req = '{1'b1, 16'h4303, cjm_pkg::op_none, 1'b0, 16'h0000, 16'h5a5a};
    @(negedge ref_clk);
    chk(pc, exp_pc);
    chk(req_ready, 1'b1);
    req = '{1'b1, {`CJM_JUMP_TOP, 3'h7, 10'h004}, cjm_pkg::op_jump, 1'b0,
           16'h0000, 16'h5a5a};
    exp_pc = exp_pc + 16'h000a;
    @(negedge ref_clk);
    chk(pc, exp_pc);
    chk(req_ready, 1'b0);
    @(negedge ref_clk);
    chk(done, 1'b1);
    req.valid = 1'b0;
    @(negedge ref_clk);
    chk(pc, exp_pc);
    chk(jump_taken, 1'b1);
  endtask : refusals
  // Reset for five cycles, check idle values, then scenarios
  initial begin
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    exp_pc = `CJM_PC_RST;
    chk(pc, exp_pc);
    chk(req_ready, 1'b1);
    jumps();
    copies();
    refusals();
    finish_test();
  end
endmodule : cond_jump_and_move_exec_tb_top
